// >>> include/lpm_defines.svh
/*
 * register offsets, field positions and reset values of the operating-mode
 * controller. assumes a 32-bit avalon-mm slave with byte addresses.
 */
`ifndef LPM_DEFINES_SVH
`define LPM_DEFINES_SVH

`define LPM_ADDR_W 4
`define LPM_REG_MODE 4'h0
`define LPM_REG_STATUS 4'h4
`define LPM_REG_PADSEL 4'h8
`define LPM_REG_CFG 4'hC

`define LPM_MODE_LSB 0
`define LPM_MODE_MSB 2
`define LPM_STAT_ISR_BIT 3
`define LPM_STAT_SAVED_LSB 4
`define LPM_STAT_SAVED_MSB 6
`define LPM_STAT_WAKE_BIT 7
`define LPM_STAT_STATE_LSB 8
`define LPM_STAT_STATE_MSB 10
`define LPM_CRYSTAL_DRIVE_PAD_SEL_BIT 7
`define LPM_CFG_DCO_BIT 0
`define LPM_PADSEL_LSB 0
`define LPM_PADSEL_MSB 7

`define LPM_PADSEL_RST 8'h80
`define LPM_CFG_RST 1'b1
`define LPM_ERASED_VECTOR 16'hFFFF
`define LPM_MODE_MAX 3'h5

`endif

// >>> include/lpm_pkg.sv
/*
 * types of the operating-mode controller: mode codes and controller states.
 * assumes nothing of its surroundings.
 */
package lpm_pkg;

    typedef enum logic [2:0] {
        full_run_mode     = 3'b000,
        sleep_level_zero  = 3'b001,
        sleep_level_one   = 3'b010,
        sleep_level_two   = 3'b011,
        sleep_level_three = 3'b100,
        sleep_level_four  = 3'b101
    } mode_t;

    typedef enum logic [2:0] {
        st_boot   = 3'b000,
        st_active = 3'b001,
        st_sleep  = 3'b010,
        st_wake   = 3'b011,
        st_isr    = 3'b100
    } ctl_state_t;

endpackage

// >>> logic/low_power_mode_clock_gater.sv
/*
 * operating-mode controller: picks the run mode or one of five sleep levels,
 * gates the processor and its clocks, wakes on interrupt and restores the
 * previous sleep level on handler return; also owns the crystal pad select.
 * assumes the processor core, interrupt logic and flash word port share
 * core_clk, and an avalon-mm master with waitrequest reaches the registers.
 */
// Functional notes
// RULE_01 - six modes set by software: one run mode, five sleep levels halting the cpu.
// RULE_02 - run mode keeps main, sub-main and auxiliary clocks all running.
// RULE_03 - sleep level zero halts cpu, stops main clock, keeps sub-main and auxiliary.
// RULE_04 - sleep level one gates like level zero; dc generator off if oscillator unused.
// RULE_05 - sleep level two stops main and sub-main clocks; auxiliary and dc generator on.
// RULE_06 - sleep level three also powers down the dc generator; only auxiliary runs.
// RULE_07 - sleep level four stops all clocks, dc generator and crystal oscillator.
// RULE_08 - interrupt in any sleep level wakes for the handler; return restores that level.
// RULE_09 - crystal driver stays on port 2 bit 7 pad until its select bit clears.
// RULE_10 - an all-ones reset vector after power-up sends the device to sleep level four.
// RULE_11 - on wake, processor clocks come back before the first fetch; return regates.
`timescale 1ns/1ps
`include "lpm_defines.svh"

module low_power_mode_clock_gater (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic [`LPM_ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic irq_pending,
    input wire logic handler_return,
    input wire logic [15:0] reset_vector,
    output logic cpu_halt,
    output logic main_clk_en,
    output logic sub_main_clock_en,
    output logic aux_clk_en,
    output logic dc_gen_en,
    output logic crystal_osc_en,
    output logic crystal_drive_pad_attach,
    output lpm_pkg::mode_t current_mode
);
    import lpm_pkg::*;

    // controller state
    ctl_state_t st_r, st_nxt;
    mode_t mode_r, mode_nxt;
    mode_t saved_r, saved_nxt;
    logic woke_r, woke_nxt;

    // registers seen by software
    logic [7:0] padsel_r, padsel_nxt;
    logic dco_used_r, dco_used_nxt;

    // bus slave
    logic wait_r, wait_nxt;
    logic [31:0] rdata_r, rdata_nxt;

    // gating outputs
    logic halt_r, halt_nxt;
    logic mclk_r, mclk_nxt;
    logic sub_main_clock_r, sub_main_clock_nxt;
    logic aclk_r, aclk_nxt;
    logic dcgen_r, dcgen_nxt;
    logic xtal_r, xtal_nxt;
    logic attach_r, attach_nxt;

    logic bus_req;
    logic wr_take;
    logic mode_wr;
    logic [2:0] wr_mode;
    logic wr_mode_ok;
    mode_t ret_mode;

    assign bus_req = avs_read | avs_write;
    // a write lands on the edge at which waitrequest is seen low
    assign wr_take = avs_write & ~wait_r & avs_byteenable[0];
    assign wr_mode = avs_writedata[`LPM_MODE_MSB:`LPM_MODE_LSB];
    // codes above the last sleep level are refused and the mode stays
    assign wr_mode_ok = (wr_mode <= `LPM_MODE_MAX); // see RULE_01
    assign mode_wr = wr_take & (avs_address == `LPM_REG_MODE) & wr_mode_ok;
    // level to fall back to on handler return; a write in the same cycle wins
    assign ret_mode = mode_wr ? mode_t'(wr_mode) : saved_r;

    // avalon slave: one wait cycle, then a single-cycle acknowledge
    always_comb begin
        wait_nxt = 1'b1;
        rdata_nxt = rdata_r;
        if (bus_req && wait_r) begin
            wait_nxt = 1'b0;
            rdata_nxt = 32'h0000_0000;
            // captured on the seeing edge so the data stand at the acknowledge edge
            if (avs_read) begin
                unique case (avs_address)
                    `LPM_REG_MODE: begin
                        rdata_nxt[`LPM_MODE_MSB:`LPM_MODE_LSB] = mode_r;
                    end
                    `LPM_REG_STATUS: begin
                        rdata_nxt[`LPM_MODE_MSB:`LPM_MODE_LSB] = mode_r;
                        rdata_nxt[`LPM_STAT_ISR_BIT] = (st_r == st_isr);
                        rdata_nxt[`LPM_STAT_SAVED_MSB:`LPM_STAT_SAVED_LSB] = saved_r;
                        rdata_nxt[`LPM_STAT_WAKE_BIT] = woke_r;
                        rdata_nxt[`LPM_STAT_STATE_MSB:`LPM_STAT_STATE_LSB] = st_r;
                    end
                    `LPM_REG_PADSEL: begin
                        rdata_nxt[`LPM_PADSEL_MSB:`LPM_PADSEL_LSB] = padsel_r;
                    end
                    `LPM_REG_CFG: begin
                        rdata_nxt[`LPM_CFG_DCO_BIT] = dco_used_r;
                    end
                    default: begin
                        rdata_nxt = 32'h0000_0000;
                    end
                endcase
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            wait_r <= 1'b1;
            rdata_r <= 32'h0000_0000;
        end else begin
            wait_r <= wait_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    // software configuration registers
    always_comb begin
        padsel_nxt = padsel_r;
        dco_used_nxt = dco_used_r;
        if (wr_take && avs_address == `LPM_REG_PADSEL) begin
            padsel_nxt = avs_writedata[`LPM_PADSEL_MSB:`LPM_PADSEL_LSB];
        end
        if (wr_take && avs_address == `LPM_REG_CFG) begin
            dco_used_nxt = avs_writedata[`LPM_CFG_DCO_BIT];
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            padsel_r <= `LPM_PADSEL_RST; // see RULE_09
            // the oscillator counts as used until software says otherwise
            dco_used_r <= `LPM_CFG_RST;
        end else begin
            padsel_r <= padsel_nxt;
            dco_used_r <= dco_used_nxt;
        end
    end

    // mode sequencer
    always_comb begin
        st_nxt = st_r;
        mode_nxt = mode_r;
        saved_nxt = saved_r;
        woke_nxt = woke_r;
        unique case (st_r)
            st_boot: begin
                // the vector word is looked at once, in the first cycle after reset
                if (reset_vector == `LPM_ERASED_VECTOR) begin
                    st_nxt = st_sleep; // see RULE_10
                    mode_nxt = sleep_level_four;
                end else begin
                    st_nxt = st_active;
                    mode_nxt = full_run_mode;
                end
            end
            st_active: begin
                if (mode_wr && wr_mode != full_run_mode) begin
                    st_nxt = st_sleep; // see RULE_01
                    mode_nxt = mode_t'(wr_mode);
                end
            end
            st_sleep: begin
                // an interrupt outranks a mode write in the same cycle
                if (irq_pending) begin
                    st_nxt = st_wake; // see RULE_08
                    saved_nxt = mode_r;
                    mode_nxt = full_run_mode;
                    woke_nxt = 1'b1;
                end else if (mode_wr) begin
                    mode_nxt = mode_t'(wr_mode);
                    if (wr_mode == full_run_mode) begin
                        st_nxt = st_active;
                    end
                end
            end
            st_wake: begin
                // clocks are back this cycle; the cpu is released next
                st_nxt = st_isr; // see RULE_11
            end
            st_isr: begin
                // a mode write inside the handler edits the level to return to
                if (mode_wr) begin
                    saved_nxt = mode_t'(wr_mode);
                end
                if (handler_return) begin
                    mode_nxt = ret_mode; // see RULE_08
                    st_nxt = (ret_mode == full_run_mode) ? st_active : st_sleep; // see RULE_11
                end
            end
            default: begin
                st_nxt = st_boot;
            end
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            st_r <= st_boot;
            mode_r <= full_run_mode;
            saved_r <= full_run_mode;
            // sticky wake flag: only reset clears it
            woke_r <= 1'b0;
        end else begin
            st_r <= st_nxt;
            mode_r <= mode_nxt;
            saved_r <= saved_nxt;
            woke_r <= woke_nxt;
        end
    end

    // clock and oscillator gating, decoded from the next mode so outputs
    // change on the same edge as the state
    always_comb begin
        halt_nxt = 1'b1;
        mclk_nxt = 1'b1;
        sub_main_clock_nxt = 1'b1;
        aclk_nxt = 1'b1;
        dcgen_nxt = 1'b1;
        xtal_nxt = 1'b1;
        unique case (mode_nxt)
            full_run_mode: begin // see RULE_02
                // handler, wake and run all see full clocks; halt only in
                // wake or boot so the first fetch follows a running main clock
                halt_nxt = (st_nxt == st_wake) || (st_nxt == st_boot); // see RULE_11
            end
            sleep_level_zero: begin
                mclk_nxt = 1'b0; // see RULE_03
            end
            sleep_level_one: begin
                mclk_nxt = 1'b0;
                dcgen_nxt = dco_used_r; // see RULE_04
            end
            sleep_level_two: begin
                mclk_nxt = 1'b0;
                sub_main_clock_nxt = 1'b0; // see RULE_05
            end
            sleep_level_three: begin
                mclk_nxt = 1'b0;
                sub_main_clock_nxt = 1'b0;
                dcgen_nxt = 1'b0; // see RULE_06
            end
            sleep_level_four: begin
                mclk_nxt = 1'b0;
                sub_main_clock_nxt = 1'b0;
                aclk_nxt = 1'b0;
                dcgen_nxt = 1'b0;
                xtal_nxt = 1'b0; // see RULE_07
            end
            default: begin
                // codes six and seven never reach mode_nxt; keep the cpu halted
                halt_nxt = 1'b1;
            end
        endcase
        // pad attach follows the select bit alone; no sleep level touches it
        attach_nxt = padsel_nxt[`LPM_CRYSTAL_DRIVE_PAD_SEL_BIT]; // see RULE_09
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            halt_r <= 1'b1;
            mclk_r <= 1'b1; // see RULE_02
            sub_main_clock_r <= 1'b1;
            aclk_r <= 1'b1;
            dcgen_r <= 1'b1;
            xtal_r <= 1'b1;
            attach_r <= 1'b1;
        end else begin
            halt_r <= halt_nxt;
            mclk_r <= mclk_nxt;
            sub_main_clock_r <= sub_main_clock_nxt;
            aclk_r <= aclk_nxt;
            dcgen_r <= dcgen_nxt;
            xtal_r <= xtal_nxt;
            attach_r <= attach_nxt;
        end
    end

    assign avs_readdata = rdata_r;
    assign avs_waitrequest = wait_r;
    assign cpu_halt = halt_r;
    assign main_clk_en = mclk_r;
    assign sub_main_clock_en = sub_main_clock_r;
    assign aux_clk_en = aclk_r;
    assign dc_gen_en = dcgen_r;
    assign crystal_osc_en = xtal_r;
    assign crystal_drive_pad_attach = attach_r;
    assign current_mode = mode_r;

endmodule

// >>> verification/lpm_props.sv
/* assertions on the mode controller's gating, wake-up and bus timing.
   bound into the controller; sees only its ports, one clock domain. */
`timescale 1ns/1ps
module lpm_props (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic avs_waitrequest,
    input wire logic irq_pending,
    input wire logic handler_return,
    input wire logic cpu_halt,
    input wire logic main_clk_en,
    input wire logic sub_main_clock_en,
    input wire logic aux_clk_en,
    input wire logic dc_gen_en,
    input wire logic crystal_osc_en,
    input wire lpm_pkg::mode_t current_mode
);
    import lpm_pkg::*;
    logic in_isr_r;
    logic dirty_r;
    mode_t saved_r;
    wire sleeping = cpu_halt && current_mode != full_run_mode;
    wire all_on = main_clk_en && sub_main_clock_en && aux_clk_en;
    default clocking @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    // level in force when a handler was entered; a bus write inside it may replace it
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            in_isr_r <= 1'b0;
            dirty_r <= 1'b0;
        end else if (sleeping && irq_pending) begin
            in_isr_r <= 1'b1;
            dirty_r <= 1'b0;
            saved_r <= current_mode;
        end else if (handler_return) begin
            in_isr_r <= 1'b0;
        end else if (in_isr_r && avs_write) begin
            dirty_r <= 1'b1;
        end
    end
    sequence s_woken;
        all_on && cpu_halt && current_mode == full_run_mode;
    endsequence
    sequence s_running;
        !cpu_halt && all_on;
    endsequence
    AST_RUN: assert property (current_mode == full_run_mode |-> all_on)
        else $error("run mode with a clock stopped");
    AST_L0: assert property (current_mode == sleep_level_zero |->
        cpu_halt && !main_clk_en && sub_main_clock_en && aux_clk_en) else $error("level zero");
    AST_L1: assert property (current_mode == sleep_level_one |->
        cpu_halt && !main_clk_en && sub_main_clock_en && aux_clk_en) else $error("level one");
    AST_L2: assert property (current_mode == sleep_level_two |-> cpu_halt && !main_clk_en
        && !sub_main_clock_en && aux_clk_en && dc_gen_en) else $error("level two");
    AST_L3: assert property (current_mode == sleep_level_three |-> cpu_halt && !main_clk_en
        && !sub_main_clock_en && aux_clk_en && !dc_gen_en) else $error("level three");
    AST_L4: assert property (current_mode == sleep_level_four |-> cpu_halt && !aux_clk_en
        && !main_clk_en && !sub_main_clock_en && !dc_gen_en && !crystal_osc_en) else $error("level four");
    AST_WAKE: assert property (sleeping && irq_pending |=> s_woken ##1 s_running)
        else $error("wake sequence wrong");
    AST_RETURN: assert property (handler_return && in_isr_r && !dirty_r && !cpu_halt
        |=> cpu_halt && current_mode == saved_r) else $error("saved level not restored");
    AST_WAIT: assert property ((avs_read || avs_write) && avs_waitrequest
        |=> !avs_waitrequest ##1 avs_waitrequest) else $error("bus answer timing");
endmodule

bind low_power_mode_clock_gater lpm_props lpm_props_inst (.core_clk, .sys_rst, .avs_read,
    .avs_write, .avs_waitrequest, .irq_pending, .handler_return, .cpu_halt, .main_clk_en,
    .sub_main_clock_en, .aux_clk_en, .dc_gen_en, .crystal_osc_en, .current_mode);

// >>> verification/core_model.sv
/* model of the processor core: raises a wake request, runs a handler of set
   length once the halt drops, then signals the return. shares core_clk. */
`timescale 1ns/1ps
module core_model (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic irq_req,
    input wire logic [3:0] ret_delay,
    input wire logic cpu_halt,
    output logic irq_pending,
    output logic handler_return
);
    logic halt_q;
    logic busy_r;
    logic [3:0] cnt_r;
    always_ff @(posedge core_clk) begin
        halt_q <= cpu_halt;
        handler_return <= 1'b0;
        if (sys_rst) begin
            irq_pending <= 1'b0;
            busy_r <= 1'b0;
        end else if (irq_pending && halt_q && !cpu_halt) begin
            // handler entered: request taken, time its run
            irq_pending <= 1'b0;
            busy_r <= 1'b1;
            cnt_r <= ret_delay;
        end else if (busy_r && cnt_r == 4'h0) begin
            handler_return <= 1'b1;
            busy_r <= 1'b0;
        end else begin
            if (irq_req) irq_pending <= 1'b1;
            if (busy_r) cnt_r <= cnt_r - 4'h1;
        end
    end
endmodule

// >>> verification/low_power_mode_clock_gater_test.sv
/* self-checking bench of the mode controller with a core model on its far
   side; registers are reached through an avalon-mm master task. */
`timescale 1ns/1ps
`include "lpm_defines.svh"
module low_power_mode_clock_gater_test;
    import lpm_pkg::*;
    logic core_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [3:0] avs_address = 4'h0;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [3:0] avs_byteenable = 4'hF;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic irq_pending, handler_return, cpu_halt, main_clk_en, sub_main_clock_en;
    logic aux_clk_en, dc_gen_en, crystal_osc_en, crystal_drive_pad_attach;
    logic [15:0] reset_vector = 16'hC000;
    logic irq_req = 1'b0;
    logic [3:0] ret_delay = 4'h0;
    logic [31:0] rdata;
    mode_t current_mode;
    int failures = 0;
    int check_count = 0;
    wire [5:0] gates = {cpu_halt, main_clk_en, sub_main_clock_en, aux_clk_en, dc_gen_en,
        crystal_osc_en};
    low_power_mode_clock_gater low_power_mode_clock_gater_inst (.core_clk, .sys_rst,
        .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata,
        .avs_waitrequest, .irq_pending, .handler_return, .reset_vector, .cpu_halt,
        .main_clk_en, .sub_main_clock_en, .aux_clk_en, .dc_gen_en, .crystal_osc_en,
        .crystal_drive_pad_attach, .current_mode);
    core_model core_model_inst (.core_clk, .sys_rst, .irq_req, .ret_delay, .cpu_halt,
        .irq_pending, .handler_return);
    always #4 core_clk = ~core_clk;
    // halt, main, sub-main, aux, dc generator, crystal for each mode code
    function automatic logic [5:0] gate_of(input logic [2:0] c, input logic cfg);
        case (c)
            3'h0: gate_of = 6'h1F;
            3'h1: gate_of = 6'h2F;
            3'h2: gate_of = {4'hB, cfg, 1'b1};
            3'h3: gate_of = 6'h27;
            3'h4: gate_of = 6'h25;
            default: gate_of = 6'h20;
        endcase
    endfunction
    task chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            failures++;
            $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask
    task bus(input logic wr, input logic [3:0] a, input logic [31:0] d, input logic [3:0] be);
        int n;
        n = 0;
        @(posedge core_clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_byteenable <= be;
        avs_write <= wr;
        avs_read <= !wr;
        do begin
            @(posedge core_clk);
            n++;
        end while (avs_waitrequest !== 1'b0);
        rdata = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        chk(32'(n), 32'h2);
    endtask
    task do_reset(input logic [15:0] v);
        reset_vector <= v;
        sys_rst <= 1'b1;
        repeat (2) @(posedge core_clk);
        sys_rst <= 1'b0;
        repeat (3) @(posedge core_clk);
    endtask
    task set_mode(input logic [2:0] c);
        bus(1'b1, `LPM_REG_MODE, {29'h0, c}, 4'hF);
        repeat (2) @(posedge core_clk);
    endtask
    task t_boot;
        chk(32'(gates), 32'h1F);
        chk(32'(crystal_drive_pad_attach), 32'h1);
        bus(1'b0, `LPM_REG_PADSEL, 32'h0, 4'hF);
        chk(rdata, 32'h80);
        bus(1'b0, `LPM_REG_CFG, 32'h0, 4'hF);
        chk(rdata, 32'h1);
        bus(1'b0, 4'h2, 32'h0, 4'hF);
        chk(rdata, 32'h0);
        $display("boot test done");
    endtask
    task t_levels(input logic cfg);
        bus(1'b1, `LPM_REG_CFG, {31'h0, cfg}, 4'hF);
        for (int c = 1; c <= 5; c++) begin
            set_mode(3'(c));
            chk(32'(current_mode), 32'(c));
            chk(32'(gates), 32'(gate_of(3'(c), cfg)));
            set_mode(3'h0);
            chk(32'(gates), 32'h1F);
        end
        $display("level test done");
    endtask
    task t_refuse;
        set_mode(3'h6);
        bus(1'b1, `LPM_REG_MODE, 32'h3, 4'h0);
        bus(1'b1, 4'h2, 32'h3, 4'hF);
        chk(32'(current_mode), 32'h0);
        bus(1'b1, `LPM_REG_PADSEL, 32'h0, 4'hF);
        repeat (2) @(posedge core_clk);
        chk(32'(crystal_drive_pad_attach), 32'h0);
        bus(1'b1, `LPM_REG_PADSEL, 32'h80, 4'hF);
        $display("refusal test done");
    endtask
    task t_wake;
        int n;
        bus(1'b1, `LPM_REG_CFG, 32'h1, 4'hF);
        for (int c = 1; c <= 5; c++) begin
            ret_delay <= c[0] ? 4'h0 : 4'h9;
            set_mode(3'(c));
            irq_req <= 1'b1;
            @(posedge core_clk);
            irq_req <= 1'b0;
            n = 0;
            do begin
                @(posedge core_clk);
                n++;
            end while (cpu_halt !== 1'b0);
            chk(32'(n), 32'h3);
            chk(32'(gates), 32'h1F);
            do @(posedge core_clk); while (handler_return !== 1'b1);
            @(posedge core_clk);
            chk(32'(current_mode), 32'(c));
            chk(32'(gates), 32'(gate_of(3'(c), 1'b1)));
            set_mode(3'h0);
        end
        // a mode write inside the handler replaces the level returned to
        ret_delay <= 4'h9;
        set_mode(3'h3);
        irq_req <= 1'b1;
        @(posedge core_clk);
        irq_req <= 1'b0;
        do @(posedge core_clk); while (cpu_halt !== 1'b0);
        bus(1'b1, `LPM_REG_MODE, 32'h0, 4'hF);
        do @(posedge core_clk); while (handler_return !== 1'b1);
        @(posedge core_clk);
        chk(32'(current_mode), 32'h0);
        chk(32'(gates), 32'h1F);
        bus(1'b0, `LPM_REG_STATUS, 32'h0, 4'hF);
        chk(rdata, 32'h180);
        $display("wake test done");
    endtask
    task t_erased;
        do_reset(16'hFFFF);
        chk(32'(current_mode), 32'h5);
        chk(32'(gates), 32'h20);
        do_reset(16'hC000);
        chk(32'(current_mode), 32'h0);
        $display("erased vector test done");
    endtask
    task print_verdict;
        $display("checks %0d, mismatches %0d", check_count, failures);
        if (failures == 0 && check_count > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        do_reset(16'hC000);
        t_boot;
        t_levels(1'b1);
        t_levels(1'b0);
        t_refuse;
        t_wake;
        t_erased;
        print_verdict;
    end
    initial begin
        #100000;
        failures++;
        print_verdict;
    end
endmodule
